//--- rtl/gpib_entry_timer.sv
// front-panel entry timer that drops a stale return-to-local request
`timescale 1ns/100ps
`include "gpib_rl_map.svh"
module gpib_entry_timer #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int TIMEOUT_MS  = `RTL_TIMEOUT_MS
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic keyPress,
	input  wire logic entryDone,
	output logic      entryActive
);

	logic [17:0] tickCnt_q;   // divider to a millisecond enable
	logic [13:0] msCnt_q;     // milliseconds since last key
	logic        active_q;    // entry in progress
	wire logic   tick = (tickCnt_q == 18'(TICK_CYCLES - 1));

	assign entryActive = active_q;

	//////////////////////////////////////////////////////////////////////
	// millisecond divider, free running
	always_ff @(posedge clk_sys) begin
		if (rst || tick) begin
			tickCnt_q <= 18'h0_0000;
		end else begin
			tickCnt_q <= tickCnt_q + 18'h0_0001;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// entry hold and timeout
	always_ff @(posedge clk_sys) begin
		if (rst || entryDone) begin
			active_q <= 1'b0;
			msCnt_q  <= 14'h0000;
		end else if (keyPress) begin
			// each key restarts the window
			active_q <= 1'b1;
			msCnt_q  <= 14'h0000;
		end else if (active_q && tick) begin
			if (msCnt_q == 14'(TIMEOUT_MS - 1)) begin
				active_q <= 1'b0;
			end
			msCnt_q <= msCnt_q + 14'h0001;
		end
	end

endmodule

//--- rtl/gpib_msg_decode.sv
// decoder of attention command bytes into interface message pulses
`timescale 1ns/100ps
module gpib_msg_decode
	import gpib_rl_pkg::*;
(
	input  wire bus_byte_type byteIn,
	input  wire logic [4:0]   primaryAddr,
	output msg_type           msg
);
`include "gpib_rl_map.svh"

	// compare helper shared by every command
	function automatic logic isCmd(input bus_byte_type b, input logic [7:0] c);
		isCmd = b.valid && b.atn && (b.data[6:0] == c[6:0]);
	endfunction

	wire logic [7:0] listenAddr = `LISTEN_BASE + {3'b000, primaryAddr};
	wire logic [7:0] talkAddr   = `TALK_BASE + {3'b000, primaryAddr};
	// talk group bytes excluding untalk
	wire logic       talkGroup  = byteIn.valid && byteIn.atn
		&& (byteIn.data[6:5] == 2'b10) && (byteIn.data[6:0] != 7'(`CMD_UNT));

	assign msg.unl       = isCmd(byteIn, `CMD_UNL);
	assign msg.unt       = isCmd(byteIn, `CMD_UNT);
	assign msg.mla       = isCmd(byteIn, listenAddr);
	assign msg.mta       = isCmd(byteIn, talkAddr);
	// another device's talk address unaddresses our talker
	assign msg.otherTalk = talkGroup && (byteIn.data[6:0] != talkAddr[6:0]);
	assign msg.dcl       = isCmd(byteIn, `CMD_DCL);
	assign msg.sdc       = isCmd(byteIn, `CMD_SDC);
	assign msg.get       = isCmd(byteIn, `CMD_GET);
	assign msg.llo       = isCmd(byteIn, `CMD_LLO);
	assign msg.gtl       = isCmd(byteIn, `CMD_GTL);
	assign msg.spe       = isCmd(byteIn, `CMD_SPE);
	assign msg.spd       = isCmd(byteIn, `CMD_SPD);

endmodule

//--- rtl/gpib_remote_local.sv
// device-side addressing, clear, trigger, poll and remote-local logic
`timescale 1ns/100ps
`include "gpib_rl_map.svh"
module gpib_remote_local
	import gpib_rl_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int TIMEOUT_MS  = `RTL_TIMEOUT_MS,
	parameter int SET_W       = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire bus_byte_type     busByte,
	input  wire logic [4:0]       primaryAddr,
	input  wire logic             ifcActive,
	input  wire logic             renActive,
	input  wire fire_mode_type    fireMode,
	input  wire logic             fireFromBus,
	input  wire logic             panelKey,
	input  wire logic             panelSetKey,
	input  wire logic             panelExec,
	input  wire logic [SET_W-1:0] panelSetting,
	input  wire logic             hostCmdValid,
	input  wire logic             hostCmdQuery,
	input  wire logic [SET_W-1:0] hostSetting,
	input  wire logic             cmdPending,
	output logic                  listenerActive,
	output logic                  talkerActive,
	output logic                  addressedLamp,
	output logic                  remoteLamp,
	output rl_state_type          rlState,
	output logic                  serialPollMode,
	output logic                  devClear,
	output logic                  triggerFire,
	output logic                  cmdExecute,
	output logic                  cmdError,
	output logic                  rtlError,
	output logic [SET_W-1:0]      currentSettings,
	output logic                  panelAccept
);

	//////////////////////////////////////////////////////////////////////
	// state and decoded messages
	// every state bit is reset synchronously; interface clear only
	// touches addressing and poll mode, never the remote-local state
	msg_type          msg;                 // one-cycle interface messages
	logic             lacs_q;              // listener addressed
	logic             tacs_q;              // talker addressed
	logic             spms_q;              // serial poll mode
	rl_state_type     rl_q;                // remote-local state
	rl_state_type     rl_d;
	logic             addrLamp_q;
	logic             remLamp_q;
	logic             clr_q;
	logic             single_shot_firing_q;
	logic             exec_q;
	logic             err_q;
	logic             rtlErr_q;
	logic             panelOk_q;
	logic [SET_W-1:0] set_q;               // current settings record
	logic             entryActive;         // panel entry in progress

	// decoder is purely combinational; its pulses last as long as valid
	gpib_msg_decode u_decode (
		.byteIn      (busByte),
		.primaryAddr (primaryAddr),
		.msg         (msg)
	);

	// panel setting keys are the only source of return-to-local
	// the timeout keeps an abandoned entry from holding rtl for ever
	gpib_entry_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.TIMEOUT_MS  (TIMEOUT_MS)
	) u_timer (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.keyPress    (panelKey && panelSetKey),
		.entryDone   (panelExec),
		.entryActive (entryActive)
	);

	//////////////////////////////////////////////////////////////////////
	// decode terms
	// terms are combinational so each message acts on the edge that takes it
	// address match comes from the decoder
	wire logic listenNext = (lacs_q || msg.mla) && !msg.unl;
	// own listen address or another talker drops ours
	wire logic talkNext   = (tacs_q || msg.mta) && !msg.unt && !msg.mla
		&& !msg.otherTalk;
	// return-to-local held through entry or on the key itself
	wire logic rtl        = entryActive || (panelKey && panelSetKey);
	// both local states run queries only
	wire logic isLocal    = (rl_q == LOCS) || (rl_q == LWLS);
	wire logic clearHit   = msg.dcl || (msg.sdc && lacs_q);
	// gated firing never takes a bus trigger
	// trigger qualifiers
	wire logic modeOk     = (fireMode == FIRE_SINGLE) || (fireMode == FIRE_FREE)
		|| (fireMode == FIRE_BURST);
	wire logic getHit     = msg.get && lacs_q && modeOk && fireFromBus;
	wire logic lloHit     = msg.llo && lacs_q;
	wire logic gtlHit     = msg.gtl && lacs_q;
	// controller commands act only when listening and not cleared
	// a clear in the same cycle wins, so that command counts as discarded
	wire logic hostTake   = hostCmdValid && lacs_q && !clearHit;
	wire logic hostReject = hostTake && !hostCmdQuery && isLocal;
	// panel changes blocked in RWLS; accepted in local states
	wire logic panelTake  = panelExec && (rl_q != RWLS);

	//////////////////////////////////////////////////////////////////////
	// arcs: LOCS to LWLS on lockout, to REMS on a taken command without rtl;
	// REMS to RWLS on lockout, to LOCS on go-to-local or rtl;
	// LWLS to RWLS on a taken command, RWLS to LWLS on go-to-local;
	// rtl is never consulted in the two lockout states
	// remote enable low beats every arc; lockout beats rtl in REMS so a
	// controller that locks the panel out keeps the remote state
	// remote-local next state
	always_comb begin
		rl_d = rl_q;
		case (rl_q)
			LOCS: begin
				if (lloHit) begin
					rl_d = LWLS;
				end else if (lacs_q && !rtl && hostTake) begin
					rl_d = REMS;
				end
			end
			REMS: begin
				// lockout first so a simultaneous rtl cannot escape it
				if (lloHit) begin
					rl_d = RWLS;
				end else if (gtlHit || rtl) begin
					rl_d = LOCS;
				end
			end
			LWLS: begin
				// rtl does not hold the device local here
				if (hostTake) begin
					rl_d = RWLS;
				end
			end
			RWLS: begin
				// panel rtl ignored, only the controller releases lockout
				if (gtlHit) begin
					rl_d = LWLS;
				end
			end
			default: begin
				// no spare codes exist, but recover to local anyway
				rl_d = LOCS;
			end
		endcase
		if (!renActive) begin
			rl_d = LOCS;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// interface clear is a level, so holding it keeps both functions idle;
	// unlisten and untalk are folded into listenNext and talkNext
	// addressing state
	always_ff @(posedge clk_sys) begin
		if (rst || ifcActive) begin
			lacs_q <= 1'b0;
			tacs_q <= 1'b0;
		end else begin
			lacs_q <= listenNext;
			tacs_q <= talkNext;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || ifcActive || msg.spd) begin
			spms_q <= 1'b0;
		end else if (msg.spe) begin
			spms_q <= 1'b1;
		end
	end

	// remote enable acts through rl_d, not as a reset of this register
	// remote-local state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rl_q <= LOCS;
		end else begin
			rl_q <= rl_d;
		end
	end

	// a lamp one cycle late would disagree with the state it shows
	// lamps follow next state so they match the registers
	always_ff @(posedge clk_sys) begin
		if (rst || ifcActive) begin
			addrLamp_q <= 1'b0;
		end else begin
			addrLamp_q <= listenNext || talkNext;
		end
	end

	// remote lamp loads from rl_d for the same reason
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			remLamp_q <= 1'b0;
		end else begin
			remLamp_q <= (rl_d == REMS) || (rl_d == RWLS);
		end
	end

	// one-cycle pulses; a slow consumer must latch them itself
	// clear pulse; trigger pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clr_q  <= 1'b0;
			single_shot_firing_q <= 1'b0;
		end else begin
			clr_q  <= clearHit;
			single_shot_firing_q <= getHit;
		end
	end

	// a rejected command still moves LOCS to REMS; the error is its only cost
	// command execute or reject; error on pending at panel exit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			exec_q   <= 1'b0;
			err_q    <= 1'b0;
			rtlErr_q <= 1'b0;
		end else begin
			exec_q   <= hostTake && !hostReject;
			err_q    <= hostReject;
			// go-to-local exit never flags pending work
			rtlErr_q <= (rl_q == REMS) && rtl && renActive && !lloHit
				&& cmdPending;
		end
	end

	// host write and panel execute in one cycle: the host wins, the panel
	// value is lost and panelAccept still pulses; queries never write
	// one settings record; transitions leave it alone
	// unexecuted entries never reach set_q since only execution writes; the timeout only ends rtl
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			set_q     <= '0;
			panelOk_q <= 1'b0;
		end else begin
			panelOk_q <= panelTake;
			if (hostTake && !hostReject && !hostCmdQuery) begin
				set_q <= hostSetting;
			end else if (panelTake) begin
				set_q <= panelSetting;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	// each pin copies one register, so no pin can glitch
	assign listenerActive  = lacs_q;
	assign talkerActive    = tacs_q;
	assign addressedLamp   = addrLamp_q;
	assign remoteLamp      = remLamp_q;
	assign rlState         = rl_q;
	assign serialPollMode  = spms_q;
	assign devClear        = clr_q;
	assign triggerFire     = single_shot_firing_q;
	assign cmdExecute      = exec_q;
	assign cmdError        = err_q;
	assign rtlError        = rtlErr_q;
	assign currentSettings = set_q;
	assign panelAccept     = panelOk_q;

endmodule

//--- rtl/gpib_rl_map.svh
// command bytes, address bases and timing counts of the remote-local block
`ifndef GPIB_RL_MAP_SVH
`define GPIB_RL_MAP_SVH

// interface command bytes, sent with attention asserted
`define CMD_GTL         8'h01
`define CMD_SDC         8'h04
`define CMD_GET         8'h08
`define CMD_LLO         8'h11
`define CMD_DCL         8'h14
`define CMD_SPE         8'h18
`define CMD_SPD         8'h19
`define CMD_UNL         8'h3F
`define CMD_UNT         8'h5F
// address group bases
`define LISTEN_BASE     8'h20
`define TALK_BASE       8'h40
// least interface clear pulse, microseconds
`define IFC_MIN_US      100
// front-panel entry timeout, milliseconds (5 to 10 s allowed)
`define RTL_TIMEOUT_MS  7000
// clock rate in kHz
`define CLK_KHZ         125000
// cycles per millisecond tick
`define TICK_CYCLES     (`CLK_KHZ)

`endif

//--- rtl/gpib_rl_pkg.sv
// types shared by the remote-local block
package gpib_rl_pkg;

	// remote-local states
	typedef enum logic [1:0] {
		LOCS = 2'b00,
		REMS = 2'b01,
		LWLS = 2'b10,
		RWLS = 2'b11
	} rl_state_type;

	// trigger firing modes
	typedef enum logic [1:0] {
		FIRE_SINGLE = 2'b00,
		FIRE_FREE   = 2'b01,
		FIRE_BURST  = 2'b10,
		FIRE_GATED  = 2'b11
	} fire_mode_type;

	// one received command byte with its attention flag
	typedef struct packed {
		logic       valid;
		logic       atn;
		logic [7:0] data;
	} bus_byte_type;

	// decoded interface messages, one-cycle pulses
	typedef struct packed {
		logic unl;
		logic unt;
		logic mla;
		logic mta;
		logic otherTalk;
		logic dcl;
		logic sdc;
		logic get;
		logic llo;
		logic gtl;
		logic spe;
		logic spd;
	} msg_type;

endpackage

//--- test/gpib_controller_model.sv
// behavioural bus controller: attention bytes, interface clear, remote enable
`timescale 1ns/100ps
`include "gpib_rl_map.svh"
module gpib_controller_model
	import gpib_rl_pkg::*;
#(
	parameter int IFC_CYCLES = (`IFC_MIN_US * 1000) / 8
) (
	input  wire logic    clk_sys,
	output bus_byte_type busByte,
	output logic         ifcActive,
	output logic         renActive
);
	initial begin
		busByte = '{1'b0, 1'b0, 8'h00};
		ifcActive = 1'b0;
		renActive = 1'b1;
	end
	// one byte for one cycle; released lines show the inverse, never the stale byte
	task automatic sendCmd(input logic [7:0] b);
		@(posedge clk_sys);
		#1;
		busByte = '{1'b1, 1'b1, b};
		@(posedge clk_sys);
		#1;
		busByte = '{1'b0, 1'b1, ~b};
	endtask
	task automatic pulseIfc();
		@(posedge clk_sys);
		#1;
		ifcActive = 1'b1;
		repeat (IFC_CYCLES) @(posedge clk_sys);
		#1;
		ifcActive = 1'b0;
	endtask
	task automatic setRen(input logic v);
		@(posedge clk_sys);
		#1;
		renActive = v;
		@(posedge clk_sys);
		#1;
	endtask
endmodule

//--- test/gpib_remote_local_test.sv
// self-checking bench of the remote-local block
`timescale 1ns/100ps
`include "gpib_rl_map.svh"
module gpib_remote_local_test;
	import gpib_rl_pkg::*;
	logic          clk_sys = 1'b0, rst = 1'b1;
	bus_byte_type  busByte;
	logic          ifcActive, renActive, sawRtl = 1'b0;
	logic [4:0]    primaryAddr = 5'h0B;
	fire_mode_type fireMode = FIRE_SINGLE;
	logic          fireFromBus = 1'b1, panelKey = 1'b0, panelSetKey = 1'b0, panelExec = 1'b0;
	logic          hostCmdValid = 1'b0, hostCmdQuery = 1'b0, cmdPending = 1'b0;
	logic [15:0]   panelSetting = 16'h1234, hostSetting = 16'h0000, currentSettings;
	logic          listenerActive, talkerActive, addressedLamp, remoteLamp, serialPollMode;
	logic          devClear, triggerFire, cmdExecute, cmdError, rtlError, panelAccept;
	rl_state_type  rlState;
	int            fail_count = 0, n_checks = 0, cycles = 0;
	wire [7:0]     myListen = `LISTEN_BASE + 8'(primaryAddr);
	wire [7:0]     myTalk = `TALK_BASE + 8'(primaryAddr);
	always #4 clk_sys = ~clk_sys;
	gpib_controller_model ctl (.clk_sys, .busByte, .ifcActive, .renActive);
	// short entry timeout: 4 cycles a tick, 5 ticks
	gpib_remote_local #(.TICK_CYCLES(4), .TIMEOUT_MS(5)) dut (.clk_sys, .rst, .busByte,
		.primaryAddr, .ifcActive, .renActive, .fireMode, .fireFromBus, .panelKey, .panelSetKey,
		.panelExec, .panelSetting, .hostCmdValid, .hostCmdQuery, .hostSetting, .cmdPending,
		.listenerActive, .talkerActive, .addressedLamp, .remoteLamp, .rlState, .serialPollMode,
		.devClear, .triggerFire, .cmdExecute, .cmdError, .rtlError, .currentSettings, .panelAccept);
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, and a sticky copy of the error pulse
	always @(posedge clk_sys) begin
		cycles++;
		if (rtlError === 1'b1) sawRtl = 1'b1;
		if (cycles == 20000) begin
			fail_count++;
			$display("ERROR %0t timeout", $time);
			end_sim();
		end
	end
	task automatic chkBit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t bit %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t value %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic hostCmd(input logic q, input logic [15:0] v);
		step();
		hostCmdValid = 1'b1;
		hostCmdQuery = q;
		hostSetting = v;
		step();
		hostCmdValid = 1'b0;
	endtask
	task automatic t_addr();
		ctl.sendCmd(myListen);
		chkBit(listenerActive & addressedLamp, 1'b1);
		ctl.sendCmd(myTalk);
		chkBit(talkerActive, 1'b1);
		ctl.sendCmd(`CMD_UNT);
		chkBit(talkerActive, 1'b0);
		ctl.sendCmd(myTalk);
		ctl.sendCmd(myListen);
		chkBit(talkerActive, 1'b0);
		ctl.sendCmd(`CMD_UNL);
		chkBit(listenerActive | addressedLamp, 1'b0);
	endtask
	task automatic t_clear();
		ctl.sendCmd(`CMD_DCL);
		chkBit(devClear, 1'b1);
		ctl.sendCmd(`CMD_SDC);
		chkBit(devClear, 1'b0);
		ctl.sendCmd(myListen);
		ctl.sendCmd(`CMD_SDC);
		chkBit(devClear, 1'b1);
	endtask
	// every firing mode, then bus source off, then unaddressed
	task automatic t_single_shot_firing();
		for (int m = 0; m < 6; m++) begin
			fireMode = fire_mode_type'(m % 4);
			fireFromBus = (m != 4);
			if (m == 5) ctl.sendCmd(`CMD_UNL);
			ctl.sendCmd(`CMD_GET);
			chkBit(triggerFire, m < 3);
		end
		fireMode = FIRE_SINGLE;
		fireFromBus = 1'b1;
	endtask
	task automatic t_poll();
		ctl.sendCmd(myTalk);
		ctl.sendCmd(`CMD_SPE);
		chkBit(serialPollMode, 1'b1);
		ctl.sendCmd(`CMD_SPD);
		chkBit(serialPollMode, 1'b0);
		ctl.sendCmd(myTalk ^ 8'h01);
		chkBit(talkerActive, 1'b0);
	endtask
	task automatic t_remote();
		ctl.sendCmd(myListen);
		hostCmd(1'b0, 16'h5A5A);
		chkBit(cmdError, 1'b1);
		chkVal(16'(rlState), 16'(REMS));
		hostCmd(1'b0, 16'hA5C3);
		chkBit(cmdExecute & remoteLamp, 1'b1);
		ctl.sendCmd(`CMD_LLO);
		chkVal(16'(rlState), 16'(RWLS));
		panelExec = 1'b1;
		step();
		chkBit(panelAccept, 1'b0);
		panelExec = 1'b0;
		step();
		chkVal(currentSettings, 16'hA5C3);
		ctl.sendCmd(`CMD_GTL);
		chkVal(16'(rlState), 16'(LWLS));
		// a setting key in lockout-local must not stop the move to remote
		panelSetKey = 1'b1;
		panelKey = 1'b1;
		step();
		panelKey = 1'b0;
		hostCmd(1'b1, 16'h0000);
		chkVal(16'(rlState), 16'(RWLS));
		ctl.sendCmd(`CMD_GTL);
		panelExec = 1'b1;
		step();
		panelExec = 1'b0;
		chkBit(panelAccept, 1'b1);
		chkVal(currentSettings, 16'h1234);
		ctl.setRen(1'b0);
		chkVal(16'(rlState), 16'(LOCS));
		ctl.setRen(1'b1);
	endtask
	task automatic t_panel();
		hostCmd(1'b1, 16'h0000);
		chkBit(cmdExecute, 1'b1);
		cmdPending = 1'b1;
		panelSetKey = 1'b1;
		panelKey = 1'b1;
		step();
		panelKey = 1'b0;
		step();
		chkVal(16'(rlState), 16'(LOCS));
		chkBit(sawRtl, 1'b1);
		cmdPending = 1'b0;
		hostCmd(1'b1, 16'h0000);
		chkVal(16'(rlState), 16'(LOCS));
		repeat (30) step();
		hostCmd(1'b1, 16'h0000);
		chkVal(16'(rlState), 16'(REMS));
		ctl.sendCmd(`CMD_UNL);
		ctl.sendCmd(`CMD_LLO);
		chkVal(16'(rlState), 16'(REMS));
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chkVal(16'(rlState), 16'(LOCS));
		chkBit(addressedLamp | remoteLamp, 1'b0);
		t_addr();
		t_clear();
		t_single_shot_firing();
		t_poll();
		t_remote();
		t_panel();
		ctl.sendCmd(myListen);
		ctl.pulseIfc();
		chkBit(listenerActive | talkerActive, 1'b0);
		end_sim();
	end
endmodule

//--- test/gpib_rl_checker.sv
// port-level checks of the remote-local block
`timescale 1ns/100ps
module gpib_rl_checker
	import gpib_rl_pkg::*;
(
	input wire logic          clk_sys,
	input wire logic          rst,
	input wire bus_byte_type  busByte,
	input wire logic [4:0]    primaryAddr,
	input wire logic          ifcActive,
	input wire logic          renActive,
	input wire fire_mode_type fireMode,
	input wire logic          fireFromBus,
	input wire logic          panelExec,
	input wire logic          listenerActive,
	input wire logic          talkerActive,
	input wire logic          addressedLamp,
	input wire logic          remoteLamp,
	input wire rl_state_type  rlState,
	input wire logic          devClear,
	input wire logic          triggerFire,
	input wire logic          panelAccept
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// attention byte with no clear in force, bit 7 ignored
	wire logic       atnByte = busByte.valid && busByte.atn && !ifcActive;
	wire logic [6:0] cmd     = busByte.data[6:0];
	// lockout taken while listening in the plain local state
	sequence seqLockLocal;
		atnByte && cmd == 7'h11 && listenerActive && renActive && rlState == LOCS;
	endsequence
	AST_UNL: assert property (atnByte && cmd == 7'h3F |=> !listenerActive)
		else $error("listener kept after unlisten");
	AST_UNT: assert property (atnByte && cmd == 7'h5F |=> !talkerActive)
		else $error("talker kept after untalk");
	AST_LAMP: assert property (addressedLamp == (listenerActive || talkerActive))
		else $error("addressed lamp wrong");
	AST_IFC: assert property (ifcActive |=> !listenerActive && !talkerActive)
		else $error("functions not idled by clear");
	AST_MLA: assert property (atnByte && cmd == {2'b01, primaryAddr} |=> listenerActive && !talkerActive)
		else $error("own listen address mishandled");
	AST_DCL: assert property (atnByte && cmd == 7'h14 |=> devClear)
		else $error("device clear missing");
	AST_SDC: assert property (atnByte && cmd == 7'h04 && !listenerActive |=> !devClear)
		else $error("selected clear while unaddressed");
	AST_GET: assert property (triggerFire |-> $past(atnByte && cmd == 7'h08 && listenerActive
		&& fireMode != FIRE_GATED && fireFromBus))
		else $error("trigger without its cause");
	AST_LLO: assert property (seqLockLocal |=> rlState == LWLS)
		else $error("lockout did not reach local lockout");
	AST_REN: assert property (!renActive |=> rlState == LOCS && !remoteLamp)
		else $error("remote enable false kept remote");
	AST_RLAMP: assert property (remoteLamp == (rlState == REMS || rlState == RWLS))
		else $error("remote lamp wrong");
	AST_RWLS: assert property (rlState == RWLS && renActive && panelExec |=> !panelAccept)
		else $error("panel accepted under lockout");
endmodule
bind gpib_remote_local gpib_rl_checker chk (.clk_sys, .rst, .busByte, .primaryAddr,
	.ifcActive, .renActive, .fireMode, .fireFromBus, .panelExec, .listenerActive,
	.talkerActive, .addressedLamp, .remoteLamp, .rlState, .devClear, .triggerFire, .panelAccept);
